// ### core/npf_cfg.svh
/*
 Constants of the packet framer: header layout, check values, identifier
 ranges, acknowledgement codes and the periodic output rate.
 Assumes it is included by bare name by the design files; the package does not include it.
*/
`ifndef NPF_CFG_SVH
`define NPF_CFG_SVH

// Header layout.
`define NPF_HDR_BYTES 5
`define NPF_HDR_POS_LRC 3'h0
`define NPF_HDR_POS_ID 3'h1
`define NPF_HDR_POS_LEN 3'h2
`define NPF_HDR_POS_CRC_LO 3'h3
`define NPF_HDR_POS_CRC_HI 3'h4
`define NPF_LRC_MASK 8'hff

// Payload check.
`define NPF_CRC_PRESET 16'hffff
`define NPF_CRC_POLY 16'h1021

// Identifier ranges and fixed identifiers.
`define NPF_STATE_FIRST 8'h14
`define NPF_CFG_FIRST 8'hb4
`define NPF_ID_ACK 8'h00
`define NPF_ID_REQ 8'h01
`define NPF_ID_SYS_STATE 8'h14
`define NPF_ACK_LEN 8'h04

// Acknowledgement results.
`define NPF_ACK_OK 8'h00
`define NPF_ACK_CRC_ERR 8'h01
`define NPF_ACK_BAD_SIZE 8'h02
`define NPF_ACK_BAD_RANGE 8'h03
`define NPF_ACK_FLASH_FAIL 8'h04
`define NPF_ACK_NOT_READY 8'h05
`define NPF_ACK_UNKNOWN 8'h06

// Timing.
`define NPF_CLK_HZ 40000000
`define NPF_STATE_RATE_HZ 50
`define NPF_STATE_PERIOD_CYC (`NPF_CLK_HZ / `NPF_STATE_RATE_HZ)

`endif

// ### core/npf_pkg.sv
/*
 Types of the packet framer: state enumerations, catalogue entry and the
 packed state record of the framer.
 Assumes npf_cfg.svh is on the include path.
*/
package npf_pkg;

   typedef enum logic [1:0] {NPF_CLS_SYS, NPF_CLS_STATE, NPF_CLS_CFG} npf_class_e;

   typedef enum logic [0:0] {NPF_RX_HDR, NPF_RX_PLD} npf_rx_e;

   typedef enum logic [2:0] {NPF_TX_IDLE, NPF_TX_CRC, NPF_TX_HDR, NPF_TX_PLD, NPF_TX_END} npf_tx_e;

   typedef struct packed {
      logic known;
      logic rd;
      logic wr;
      logic var_len;
      logic [7:0] len;
   } npf_cat_s;

   typedef struct packed {
      npf_rx_e rx_st;
      logic [3:0][7:0] hbuf;
      logic [2:0] hcnt;
      logic [7:0] r_id;
      logic [7:0] r_len;
      logic [15:0] r_crc;
      logic [15:0] r_run;
      logic [7:0] r_idx;
      logic [255:0] req_map;
      logic [255:0] pend;
      logic [7:0] ack_id;
      logic [15:0] ack_crc;
      logic [7:0] ack_res;
      npf_tx_e tx_st;
      logic [7:0] t_id;
      logic [7:0] t_len;
      logic [7:0] t_idx;
      logic [15:0] t_crc;
      logic [2:0] hk;
      logic [7:0] ta_id;
      logic [15:0] ta_crc;
      logic [7:0] ta_res;
      logic tx_valid;
      logic [7:0] tx_data;
      logic rxp_valid;
      logic [7:0] rxp_data;
      logic [7:0] rxp_idx;
      logic [7:0] rxp_id;
      npf_class_e rxp_class;
      logic rxp_done;
      logic rxp_ok;
      logic [31:0] tick;
   } npf_state_s;

endpackage

// ### core/npf_crc16.sv
/*
 One byte step of the sixteen-bit payload check, most significant bit first.
 Assumes the caller holds the running value and presets it itself.
*/
`timescale 1ns/1ps
`default_nettype none
`include "npf_cfg.svh"

module npf_crc16 #(
   parameter logic [15:0] POLY = `NPF_CRC_POLY
) (
   // Running value and next byte.
   input wire logic [15:0] i_crc,
   input wire logic [7:0] i_data,
   // Updated value.
   output logic [15:0] o_crc
);

   logic [15:0] c;

   always_comb begin
      c = i_crc ^ {i_data, 8'h00};
      for (int b = 0; b < 8; b++) begin
         c = c[15] ? ((c << 1) ^ POLY) : (c << 1);
      end
      o_crc = c;
   end

endmodule // npf_crc16
`default_nettype wire

// ### core/npf_framer.sv
/*
 Packet framer of the unit's binary serial protocol: finds and checks
 received packets, serves requests, acknowledges writes that pass the payload check and orders periodic
 and requested output packets onto the transmit byte stream.
 Assumes byte-wide receive and transmit streams beside a serialiser on the
 same clock, and a payload source that answers a byte index in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "npf_cfg.svh"

module npf_framer
   import npf_pkg::*;
#(
   parameter int unsigned PERIOD_CYC = `NPF_STATE_PERIOD_CYC
) (
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Receive byte stream.
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   // Transmit byte stream.
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   input wire logic i_tx_ready,
   // Received payload towards the unit.
   output logic o_rxp_valid,
   output logic [7:0] o_rxp_data,
   output logic [7:0] o_rxp_idx,
   output logic [7:0] o_rxp_id,
   output logic [1:0] o_rxp_class,
   output logic o_rxp_done,
   output logic o_rxp_ok,
   input wire logic i_not_ready,
   // Payload source for outgoing packets.
   output logic [7:0] o_src_id,
   output logic [7:0] o_src_idx,
   input wire logic [7:0] i_src_data
);

   npf_state_s s_reg;
   npf_state_s s_next;
   logic [15:0] rx_crc_nx;
   logic [15:0] tx_crc_nx;
   logic [7:0] tx_byte;

   function automatic logic [7:0] lrc_f(input logic [7:0] id, input logic [7:0] len,
                                        input logic [7:0] c0, input logic [7:0] c1);
      logic [7:0] sum;
      sum = id + len + c0 + c1;
      return (sum ^ `NPF_LRC_MASK) + 8'h01;
   endfunction

   function automatic npf_class_e class_f(input logic [7:0] id);
      if (id < `NPF_STATE_FIRST) return NPF_CLS_SYS;
      else if (id < `NPF_CFG_FIRST) return NPF_CLS_STATE;
      else return NPF_CLS_CFG;
   endfunction

   // Packet catalogue: direction and payload length per identifier.
   function automatic npf_cat_s cat_f(input logic [7:0] id);
      npf_cat_s c;
      c = '{known: 1'b1, rd: 1'b1, wr: 1'b0, var_len: 1'b0, len: 8'h00};
      unique case (id)
         8'd2, 8'd190, 8'd193: c.len = 8'd1;
         8'd191: c.len = 8'd3;
         8'd0, 8'd4, 8'd5, 8'd23, 8'd54, 8'd180, 8'd184: c.len = 8'd4;
         8'd21, 8'd48, 8'd49, 8'd52, 8'd53, 8'd56, 8'd192: c.len = 8'd8;
         8'd24, 8'd25, 8'd26, 8'd35, 8'd36, 8'd37, 8'd39, 8'd42, 8'd43, 8'd50,
         8'd57: c.len = 8'd12;
         8'd30, 8'd188: c.len = 8'd13;
         8'd22: c.len = 8'd14;
         8'd27, 8'd38, 8'd40, 8'd47, 8'd58: c.len = 8'd16;
         8'd182, 8'd186: c.len = 8'd17;
         8'd51: c.len = 8'd20;
         8'd3, 8'd32, 8'd33, 8'd46: c.len = 8'd24;
         8'd34: c.len = 8'd25;
         8'd29, 8'd41, 8'd45: c.len = 8'd36;
         8'd28: c.len = 8'd48;
         8'd189, 8'd194: c.len = 8'd49;
         8'd44: c.len = 8'd60;
         8'd185: c.len = 8'd73;
         8'd20: c.len = 8'd100;
         8'd1, 8'd31, 8'd55, 8'd181, 8'd187: c.var_len = 1'b1;
         default: c.known = 1'b0;
      endcase
      unique case (id)
         8'd1, 8'd4, 8'd5, 8'd55, 8'd190, 8'd193: begin
            c.rd = 1'b0;
            c.wr = 1'b1;
         end
         8'd2, 8'd44, 8'd45, 8'd46, 8'd47, 8'd48, 8'd52, 8'd53, 8'd56: c.wr = 1'b1;
         default: c.wr = (id >= `NPF_CFG_FIRST) && (id != 8'd191);
      endcase
      if (!c.known) begin
         c.rd = 1'b0;
         c.wr = 1'b0;
      end
      return c;
   endfunction

   npf_crc16 u_rx_crc (
      .i_crc(s_reg.r_run),
      .i_data(i_rx_data),
      .o_crc(rx_crc_nx)
   );

   npf_crc16 u_tx_crc (
      .i_crc(s_reg.t_crc),
      .i_data(tx_byte),
      .o_crc(tx_crc_nx)
   );

   // Acknowledgement payload is built here, every other payload comes from the source.
   always_comb begin
      if (s_reg.t_id == `NPF_ID_ACK) begin
         unique case (s_reg.t_idx[1:0])
            2'h0: tx_byte = s_reg.ta_id;
            2'h1: tx_byte = s_reg.ta_crc[7:0];
            2'h2: tx_byte = s_reg.ta_crc[15:8];
            2'h3: tx_byte = s_reg.ta_res;
         endcase
      end else begin
         tx_byte = i_src_data;
      end
   end

   always_comb begin
      logic fin;
      logic [15:0] fin_crc;
      logic [255:0] set_map;
      logic [255:0] clr_map;
      npf_cat_s cat;
      logic found;
      logic [7:0] pick;
      logic [7:0] hdr_byte;
      fin = 1'b0;
      fin_crc = `NPF_CRC_PRESET;
      set_map = '0;
      clr_map = '0;
      found = 1'b0;
      pick = 8'h00;
      hdr_byte = 8'h00;
      cat = '0;
      s_next = s_reg;
      s_next.rxp_valid = 1'b0;
      s_next.rxp_done = 1'b0;

      // Receive side.
      unique case (s_reg.rx_st)
         NPF_RX_HDR: begin
            if (i_rx_valid) begin
               if (s_reg.hcnt < 3'h4) begin
                  s_next.hbuf[s_reg.hcnt[1:0]] = i_rx_data;
                  s_next.hcnt = s_reg.hcnt + 3'h1;
               end else if (lrc_f(s_reg.hbuf[1], s_reg.hbuf[2], s_reg.hbuf[3], i_rx_data)
                            == s_reg.hbuf[0]) begin
                  s_next.r_id = s_reg.hbuf[1];
                  s_next.r_len = s_reg.hbuf[2];
                  s_next.r_crc = {i_rx_data, s_reg.hbuf[3]};
                  s_next.r_run = `NPF_CRC_PRESET;
                  s_next.r_idx = 8'h00;
                  s_next.req_map = '0;
                  s_next.hcnt = 3'h0;
                  s_next.rxp_id = s_reg.hbuf[1];
                  s_next.rxp_class = class_f(s_reg.hbuf[1]);
                  if (s_reg.hbuf[2] == 8'h00) begin
                     fin = 1'b1;
                  end else begin
                     s_next.rx_st = NPF_RX_PLD;
                  end
               end else begin
                  s_next.hbuf = {i_rx_data, s_reg.hbuf[3], s_reg.hbuf[2], s_reg.hbuf[1]};
               end
            end
         end
         NPF_RX_PLD: begin
            if (i_rx_valid) begin
               s_next.rxp_valid = 1'b1;
               s_next.rxp_data = i_rx_data;
               s_next.rxp_idx = s_reg.r_idx;
               s_next.r_run = rx_crc_nx;
               if (s_reg.r_id == `NPF_ID_REQ) begin
                  s_next.req_map[i_rx_data] = 1'b1;
               end
               s_next.r_idx = s_reg.r_idx + 8'h01;
               if (s_reg.r_idx == s_reg.r_len - 8'h01) begin
                  fin = 1'b1;
                  fin_crc = rx_crc_nx;
                  s_next.rx_st = NPF_RX_HDR;
               end
            end
         end
      endcase

      // End of a received packet: deliver, serve a request or acknowledge a write.
      if (fin) begin
         s_next.rxp_done = 1'b1;
         s_next.rxp_ok = (fin_crc == s_next.r_crc);
         cat = cat_f(s_next.r_id);
         if (fin_crc == s_next.r_crc) begin
            if (s_next.r_id == `NPF_ID_REQ) begin
               set_map = s_next.req_map;
            end else if (s_next.r_id != `NPF_ID_ACK) begin
               s_next.ack_id = s_next.r_id;
               s_next.ack_crc = s_next.r_crc;
               if (!cat.wr) begin
                  s_next.ack_res = `NPF_ACK_UNKNOWN;
               end else if (!cat.var_len && (s_next.r_len != cat.len)) begin
                  s_next.ack_res = `NPF_ACK_BAD_SIZE;
               end else if (i_not_ready) begin
                  s_next.ack_res = `NPF_ACK_NOT_READY;
               end else begin
                  s_next.ack_res = `NPF_ACK_OK;
               end
               set_map[`NPF_ID_ACK] = 1'b1;
            end
         end
      end

      // Periodic system state output.
      if (s_reg.tick == PERIOD_CYC - 1) begin
         s_next.tick = '0;
         set_map[`NPF_ID_SYS_STATE] = 1'b1;
      end else begin
         s_next.tick = s_reg.tick + 32'h1;
      end

      // Transmit side.
      unique case (s_reg.tx_st)
         NPF_TX_IDLE: begin
            for (int i = 255; i >= 0; i--) begin
               if (s_reg.pend[i]) begin
                  found = 1'b1;
                  pick = 8'(i);
               end
            end
            if (found) begin
               clr_map[pick] = 1'b1;
               cat = cat_f(pick);
               s_next.t_id = pick;
               s_next.t_idx = 8'h00;
               s_next.t_crc = `NPF_CRC_PRESET;
               if (pick == `NPF_ID_ACK) begin
                  s_next.t_len = `NPF_ACK_LEN;
                  s_next.ta_id = s_reg.ack_id;
                  s_next.ta_crc = s_reg.ack_crc;
                  s_next.ta_res = s_reg.ack_res;
                  s_next.tx_st = NPF_TX_CRC;
               end else if (cat.rd && !cat.var_len) begin
                  s_next.t_len = cat.len;
                  s_next.tx_st = NPF_TX_CRC;
               end
            end
         end
         NPF_TX_CRC: begin
            s_next.t_crc = tx_crc_nx;
            s_next.t_idx = s_reg.t_idx + 8'h01;
            if (s_reg.t_idx == s_reg.t_len - 8'h01) begin
               s_next.t_idx = 8'h00;
               s_next.hk = 3'h0;
               s_next.tx_st = NPF_TX_HDR;
            end
         end
         NPF_TX_HDR: begin
            unique case (s_reg.hk)
               `NPF_HDR_POS_LRC: hdr_byte = lrc_f(s_reg.t_id, s_reg.t_len, s_reg.t_crc[7:0],
                                                  s_reg.t_crc[15:8]);
               `NPF_HDR_POS_ID: hdr_byte = s_reg.t_id;
               `NPF_HDR_POS_LEN: hdr_byte = s_reg.t_len;
               `NPF_HDR_POS_CRC_LO: hdr_byte = s_reg.t_crc[7:0];
               default: hdr_byte = s_reg.t_crc[15:8];
            endcase
            if (!s_reg.tx_valid || i_tx_ready) begin
               s_next.tx_valid = 1'b1;
               s_next.tx_data = hdr_byte;
               s_next.hk = s_reg.hk + 3'h1;
               if (s_reg.hk == `NPF_HDR_POS_CRC_HI) begin
                  s_next.tx_st = NPF_TX_PLD;
               end
            end
         end
         NPF_TX_PLD: begin
            if (!s_reg.tx_valid || i_tx_ready) begin
               s_next.tx_valid = 1'b1;
               s_next.tx_data = tx_byte;
               s_next.t_idx = s_reg.t_idx + 8'h01;
               if (s_reg.t_idx == s_reg.t_len - 8'h01) begin
                  s_next.tx_st = NPF_TX_END;
               end
            end
         end
         NPF_TX_END: begin
            if (i_tx_ready) begin
               s_next.tx_valid = 1'b0;
               s_next.tx_st = NPF_TX_IDLE;
            end
         end
         default: s_next.tx_st = NPF_TX_IDLE;
      endcase

      // A new request wins over the clear of the same identifier.
      s_next.pend = (s_reg.pend & ~clr_map) | set_map;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg <= '0;
         s_reg.r_run <= `NPF_CRC_PRESET;
         s_reg.t_crc <= `NPF_CRC_PRESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_tx_valid = s_reg.tx_valid;
   assign o_tx_data = s_reg.tx_data;
   assign o_rxp_valid = s_reg.rxp_valid;
   assign o_rxp_data = s_reg.rxp_data;
   assign o_rxp_idx = s_reg.rxp_idx;
   assign o_rxp_id = s_reg.rxp_id;
   assign o_rxp_class = s_reg.rxp_class;
   assign o_rxp_done = s_reg.rxp_done;
   assign o_rxp_ok = s_reg.rxp_ok;
   assign o_src_id = s_reg.t_id;
   assign o_src_idx = s_reg.t_idx;

endmodule // npf_framer
`default_nettype wire

// ### verif/npf_framer_chk.sv
/*
 Concurrent checks on the ports of the packet framer.
 Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module npf_framer_chk
   import npf_pkg::*;
#(
   parameter int unsigned PERIOD_CYC = 800000
) (
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Streams.
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   input wire logic o_tx_valid,
   input wire logic [7:0] o_tx_data,
   input wire logic i_tx_ready,
   // Received payload.
   input wire logic o_rxp_valid,
   input wire logic [7:0] o_rxp_data,
   input wire logic [7:0] o_rxp_idx,
   input wire logic [7:0] o_rxp_id,
   input wire logic [1:0] o_rxp_class,
   input wire logic o_rxp_done,
   input wire logic o_rxp_ok
);
   logic acc;
   logic [8:0] cnt_reg;
   logic [7:0] h0_reg, hid_reg, hlen_reg, hc0_reg, sum, lrc_exp;
   logic [1:0] cls_exp;
   assign acc = o_tx_valid && i_tx_ready;
   assign sum = hid_reg + hlen_reg + hc0_reg + o_tx_data;
   assign lrc_exp = (sum ^ 8'hff) + 8'h01;
   assign cls_exp = (o_rxp_id < 8'h14) ? 2'h0 : ((o_rxp_id < 8'hb4) ? 2'h1 : 2'h2);
   // Counts accepted bytes of the current outgoing packet and keeps the first four bytes of its header.
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg <= 9'h000;
         h0_reg <= 8'h00;
         hid_reg <= 8'h00;
         hlen_reg <= 8'h00;
         hc0_reg <= 8'h00;
      end else if (!o_tx_valid) begin
         cnt_reg <= 9'h000;
      end else if (acc) begin
         cnt_reg <= cnt_reg + 9'h001;
         if (cnt_reg == 9'h000) h0_reg <= o_tx_data;
         if (cnt_reg == 9'h001) hid_reg <= o_tx_data;
         if (cnt_reg == 9'h002) hlen_reg <= o_tx_data;
         if (cnt_reg == 9'h003) hc0_reg <= o_tx_data;
      end
   end
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
      else $error("transmit byte changed before acceptance");
   a_wire_count: assert property ($fell(o_tx_valid) |-> cnt_reg == {1'b0, hlen_reg} + 9'h005)
      else $error("packet byte count differs from length plus five");
   a_hdr_lrc: assert property (acc && cnt_reg == 9'h004 |-> h0_reg == lrc_exp)
      else $error("header checksum wrong");
   a_ack_len: assert property (acc && cnt_reg == 9'h002 && hid_reg == 8'h00 |-> o_tx_data == 8'h04)
      else $error("acknowledge length not four");
   a_class_range: assert property (o_rxp_class == cls_exp)
      else $error("identifier class wrong");
   a_pld_echo: assert property (o_rxp_valid |-> $past(i_rx_valid) && o_rxp_data == $past(i_rx_data))
      else $error("payload byte not passed on");
   a_idx_step: assert property (o_rxp_valid && $past(o_rxp_valid) |-> o_rxp_idx == $past(o_rxp_idx) + 8'h01)
      else $error("payload index did not step");
   a_done_pulse: assert property (o_rxp_done |-> $past(i_rx_valid) ##1 !o_rxp_done)
      else $error("end of packet pulse wrong");
   a_idx_first: assert property (o_rxp_valid && !$past(o_rxp_valid) |-> o_rxp_idx == 8'h00)
      else $error("first payload index not zero");
   c_ack_sent: cover property (acc && cnt_reg == 9'h002 && hid_reg == 8'h00);
   c_bad_crc: cover property (o_rxp_done && !o_rxp_ok);
   c_stall: cover property (o_tx_valid && !i_tx_ready);
endmodule // npf_framer_chk

bind npf_framer npf_framer_chk #(.PERIOD_CYC(PERIOD_CYC)) npf_framer_chk_inst (
   .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
   .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready),
   .o_rxp_valid(o_rxp_valid), .o_rxp_data(o_rxp_data), .o_rxp_idx(o_rxp_idx),
   .o_rxp_id(o_rxp_id), .o_rxp_class(o_rxp_class), .o_rxp_done(o_rxp_done),
   .o_rxp_ok(o_rxp_ok));
`default_nettype wire

// ### verif/npf_host_model.sv
/*
 Host controller model: sends byte streams and collects transmitted bytes.
 Assumes the framer's byte streams on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module npf_host_model (
   // Clock.
   input wire logic i_clk_sys,
   // Byte link.
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   output logic o_tx_ready,
   // Pacing.
   input wire logic i_slow
);
   logic [7:0] got_q[$];
   logic [1:0] pace_reg = 2'h0;
   initial begin
      o_rx_valid = 1'b0;
      o_rx_data = 8'h00;
   end
   // A slow host takes one byte in four, which is still above eleven bits per byte.
   always @(posedge i_clk_sys) pace_reg <= pace_reg + 2'h1;
   assign o_tx_ready = !i_slow || pace_reg == 2'h0;
   always @(posedge i_clk_sys) begin
      if (i_tx_valid && o_tx_ready) got_q.push_back(i_tx_data);
   end
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) begin
         @(posedge i_clk_sys);
         o_rx_valid <= 1'b1;
         o_rx_data <= b[i];
      end
      @(posedge i_clk_sys);
      o_rx_valid <= 1'b0;
      o_rx_data <= ~b[b.size() - 1];
   endtask
   task automatic take(input int n, output logic [7:0] f[$]);
      int w;
      w = 0;
      while (got_q.size() < n && w < 5000) begin
         @(negedge i_clk_sys);
         w++;
      end
      f = {};
      while (f.size() < n && got_q.size() > 0) f.push_back(got_q.pop_front());
   endtask
endmodule // npf_host_model
`default_nettype wire

// ### verif/tb_top.sv
/*
 Testbench of the packet framer: acknowledges, requests, bad check, periodic output.
 Assumes the framer, its package, the checker and the host model are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import npf_pkg::*;
   localparam int unsigned PER = 2000;
   logic i_clk_sys, i_rst_n, not_ready, slow, rx_valid, tx_valid, tx_ready;
   logic rxp_valid, rxp_done, rxp_ok, last_ok;
   logic [7:0] rx_data, tx_data, rxp_data, rxp_idx, rxp_id, src_id, src_idx, src_data;
   logic [1:0] rxp_class;
   int fail_count = 0;
   int check_count = 0;
   int done_cnt = 0;
   assign src_data = src_id ^ src_idx;
   npf_framer #(.PERIOD_CYC(PER)) npf_framer_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
      .i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
      .i_tx_ready(tx_ready), .o_rxp_valid(rxp_valid), .o_rxp_data(rxp_data),
      .o_rxp_idx(rxp_idx), .o_rxp_id(rxp_id), .o_rxp_class(rxp_class), .o_rxp_done(rxp_done),
      .o_rxp_ok(rxp_ok), .i_not_ready(not_ready), .o_src_id(src_id), .o_src_idx(src_idx),
      .i_src_data(src_data));
   npf_host_model npf_host_model_inst (.i_clk_sys(i_clk_sys), .o_rx_valid(rx_valid),
      .o_rx_data(rx_data), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
      .i_slow(slow));
   initial begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      if (rxp_done) begin
         done_cnt++;
         last_ok = rxp_ok;
      end
   end
   task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic logic [15:0] crc_of(input logic [7:0] d[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (d[i]) begin
         c = c ^ {d[i], 8'h00};
         for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
      end
      return c;
   endfunction
   function automatic void frame(input logic [7:0] id, input logic [7:0] p[$],
                                 output logic [7:0] f[$]);
      logic [15:0] c;
      logic [7:0] s;
      c = crc_of(p);
      s = id + 8'(p.size()) + c[7:0] + c[15:8];
      f = p;
      f.push_front(c[15:8]);
      f.push_front(c[7:0]);
      f.push_front(8'(p.size()));
      f.push_front(id);
      f.push_front((s ^ 8'hff) + 8'h01);
   endfunction
   task automatic send_pkt(input logic [7:0] id, input logic [7:0] p[$], input bit junk,
                           input bit bad);
      logic [7:0] f[$];
      int d, n;
      d = done_cnt;
      n = 0;
      frame(id, p, f);
      if (junk) f.push_front(8'h5a);
      if (bad) f[f.size() - 1] = ~f[f.size() - 1];
      npf_host_model_inst.send(f);
      while (done_cnt == d && n < 50) begin
         @(negedge i_clk_sys);
         n++;
      end
      check("done", 8'h01, 8'(done_cnt - d));
      check("ok", {7'h00, !bad}, {7'h00, last_ok});
      check("id", id, rxp_id);
      check("class", (id < 8'h14) ? 8'h00 : ((id < 8'hb4) ? 8'h01 : 8'h02),
            {6'h00, rxp_class});
   endtask
   task automatic expect_pkt(input logic [7:0] id, input logic [7:0] p[$]);
      logic [7:0] e[$];
      logic [7:0] f[$];
      frame(id, p, e);
      npf_host_model_inst.take(e.size(), f);
      check("length", 8'(e.size()), 8'(f.size()));
      foreach (e[i]) check("byte", e[i], f[i]);
   endtask
   task automatic expect_src(input logic [7:0] id, input int len);
      logic [7:0] p[$];
      for (int i = 0; i < len; i++) p.push_back(id ^ 8'(i));
      expect_pkt(id, p);
   endtask
   task automatic t_acks();
      logic [31:0] tab[6] = '{32'hb4040000, 32'hb4030002, 32'hbf030006, 32'hb4040105,
                              32'hbe010000, 32'h2c3c0000};
      logic [7:0] p[$];
      logic [15:0] c;
      foreach (tab[k]) begin
         p.delete();
         for (int i = 0; i < tab[k][23:16]; i++) p.push_back(8'(i * 7));
         @(posedge i_clk_sys);
         not_ready <= tab[k][8];
         send_pkt(tab[k][31:24], p, k == 0, 1'b0);
         c = crc_of(p);
         expect_pkt(8'h00, '{tab[k][31:24], c[7:0], c[15:8], tab[k][7:0]});
      end
      @(posedge i_clk_sys);
      not_ready <= 1'b0;
   endtask
   task automatic t_request();
      slow <= 1'b1;
      send_pkt(8'h01, '{8'h18, 8'h1f, 8'h15}, 1'b0, 1'b0);
      expect_src(8'h15, 8);
      expect_src(8'h18, 12);
      slow <= 1'b0;
   endtask
   task automatic t_bad_crc();
      logic [7:0] p[$];
      for (int i = 0; i < 17; i++) p.push_back(8'(i));
      send_pkt(8'hb6, p, 1'b0, 1'b1);
      repeat (300) @(posedge i_clk_sys);
      check("silent", 8'h00, 8'(npf_host_model_inst.got_q.size()));
   endtask
   task automatic t_periodic();
      expect_src(8'h14, 100);
      expect_src(8'h14, 100);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      i_rst_n = 1'b0;
      not_ready = 1'b0;
      slow = 1'b0;
      repeat (8) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      t_acks();
      t_request();
      t_bad_crc();
      t_periodic();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      fail_count++;
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
